/* include/prs_pkg.sv */
package prs_pkg;

	// ----------------------------------------------------------------
	// Register port geometry and map
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned CFG_W = 16;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_CFG = 4'h4;
	localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h8;

	// Status register fields
	localparam int unsigned STAT_RUN_BIT = 0;
	localparam int unsigned STAT_HARD_BIT = 1;
	localparam int unsigned STAT_SHORT_BIT = 2;
	localparam int unsigned STAT_CFGLD_BIT = 3;
	localparam int unsigned STAT_CFGI2C_BIT = 4;
	localparam int unsigned STAT_STRAP_LSB = 5;

	// Control register fields (write-only request bits)
	localparam int unsigned CTRL_SOFT_BIT = 0;
	localparam int unsigned CTRL_HARD_BIT = 1;

	// ----------------------------------------------------------------
	// Reset values and timing counts, in input-clock cycles
	// ----------------------------------------------------------------
	localparam logic [CFG_W-1:0] CFG_RST = 16'h0000;
	localparam int unsigned CNT_W = 10;
	localparam int unsigned POR_MIN_CYC = 16;
	localparam int unsigned HRST_DELAY_CYC = 521;
	localparam int unsigned HRST_HOLD_CYC = 64;
	localparam int unsigned SRST_HOLD_CYC = 16;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] boot_mode_select;
		logic watchdog_enable_strap;
		logic host_narrow_bus_strap;
		logic host_strobe_polarity_strap;
	} prs_strap_s;
	localparam int unsigned STRAP_W = 5;
	localparam logic [STRAP_W-1:0] STRAP_RST = 5'h00;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} prs_bus_req_s;

	typedef enum logic [5:0] {
		ST_POR = 6'h01,
		ST_WAIT = 6'h02,
		ST_HREL = 6'h04,
		ST_RUN = 6'h08,
		ST_HARD = 6'h10,
		ST_SOFT = 6'h20
	} prs_state_e;

endpackage

/* verilog/prs_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module prs_sync #(
	parameter int unsigned W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	// ----------------------------------------------------------------
	// Two-flop synchroniser, one chain per bit
	// ----------------------------------------------------------------
	logic [W-1:0] meta_r;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			// First stage feeds only the second stage
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					meta_r[i] <= RST_VAL[i];
					q[i] <= RST_VAL[i];
				end else begin
					meta_r[i] <= d[i];
					q[i] <= meta_r[i];
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

/* verilog/prs_top.sv */
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Power-on reset input asserted starts reset flow
// - Straps sampled when power-on reset deasserts
// - Hard reset released 521 cycles after deassertion
// - Configuration written by host port or I2C
// - Hard and soft resets keep latched configuration
// - Power-on reset resets clocks, hard reset, core
module prs_top (
	input wire logic CORE_CLK,
	input wire logic RESET,
	input wire logic POWER_ON_RESET_IN_N,
	input wire prs_pkg::prs_strap_s STRAP_IN,
	input wire logic HARD_RESET_IO_N_I,
	output logic HARD_RESET_IO_N_O,
	output logic HARD_RESET_IO_N_OE_N,
	input wire logic INT_HARD_RESET_REQ,
	input wire logic SOFT_RESET_REQ,
	input wire logic I2C_CFG_VALID,
	input wire logic [prs_pkg::CFG_W-1:0] I2C_CFG_DATA,
	input wire prs_pkg::prs_bus_req_s BUS_REQ,
	output logic [prs_pkg::DATA_W-1:0] BUS_RDATA,
	output prs_pkg::prs_strap_s STRAP_OUT,
	output logic [prs_pkg::CFG_W-1:0] CFG_WORD,
	output logic CLOCK_GEN_RESET,
	output logic CORE_RESET
);
	import prs_pkg::*;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [STRAP_W+1:0] pins_s;
	logic por_n_s;
	prs_strap_s strap_s;
	logic hard_n_s;

	// Reset view: power-on reset asserted, hard pin released
	prs_sync #(
		.W(STRAP_W + 2),
		.RST_VAL({1'b0, STRAP_RST, 1'b1})
	) u_sync (
		.clk(CORE_CLK),
		.rst(RESET),
		.d({POWER_ON_RESET_IN_N, STRAP_IN, HARD_RESET_IO_N_I}),
		.q(pins_s)
	);
	assign por_n_s = pins_s[STRAP_W+1];
	assign strap_s = pins_s[STRAP_W:1];
	assign hard_n_s = pins_s[0];

	// ----------------------------------------------------------------
	// Register port decode
	// ----------------------------------------------------------------
	logic wr_cfg;
	logic wr_ctrl;
	logic ctrl_soft;
	logic ctrl_hard;
	logic por_flow;

	assign wr_cfg = BUS_REQ.wr && (BUS_REQ.addr == OFF_CFG);
	assign wr_ctrl = BUS_REQ.wr && (BUS_REQ.addr == OFF_CTRL);
	assign ctrl_soft = wr_ctrl && BUS_REQ.wdata[CTRL_SOFT_BIT];
	assign ctrl_hard = wr_ctrl && BUS_REQ.wdata[CTRL_HARD_BIT];

	// ----------------------------------------------------------------
	// Reset sequencer
	// ----------------------------------------------------------------
	prs_state_e state_r;
	prs_state_e state_nxt;
	logic [CNT_W-1:0] cnt_r;
	logic cnt_done;

	localparam logic [CNT_W-1:0] DELAY_LAST = CNT_W'(HRST_DELAY_CYC - 1);
	localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HRST_HOLD_CYC - 1);
	localparam logic [CNT_W-1:0] SOFT_LAST = CNT_W'(SRST_HOLD_CYC - 1);
	localparam logic [CNT_W-1:0] POR_MIN = CNT_W'(POR_MIN_CYC);

	assign por_flow = (state_r == ST_POR) || (state_r == ST_WAIT);

	// Next state; power-on reset overrides every other flow
	always_comb begin
		state_nxt = state_r;
		cnt_done = 1'b0;
		case (state_r)
			ST_POR: begin
				if (por_n_s)
					state_nxt = ST_WAIT;
			end
			ST_WAIT: begin
				cnt_done = (cnt_r == DELAY_LAST);
				if (cnt_done)
					state_nxt = ST_HREL;
			end
			ST_HREL: begin
				// Pin may be held low by the board; stay in reset until it floats up
				if (hard_n_s)
					state_nxt = ST_RUN;
			end
			ST_RUN: begin
				if (!hard_n_s || INT_HARD_RESET_REQ || ctrl_hard)
					state_nxt = ST_HARD;
				else if (SOFT_RESET_REQ || ctrl_soft)
					state_nxt = ST_SOFT;
			end
			ST_HARD: begin
				cnt_done = (cnt_r == HOLD_LAST);
				if (cnt_done)
					state_nxt = ST_HREL;
			end
			ST_SOFT: begin
				cnt_done = (cnt_r == SOFT_LAST);
				if (cnt_done)
					state_nxt = ST_RUN;
			end
			default: state_nxt = ST_POR;
		endcase
		if (!por_n_s)
			state_nxt = ST_POR;
	end

	// State register
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET)
			state_r <= ST_POR;
		else
			state_r <= state_nxt;
	end

	// Flow counter restarts on every state change
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET)
			cnt_r <= '0;
		else if (state_nxt != state_r)
			cnt_r <= '0;
		else if (state_r == ST_POR) begin
			if (cnt_r != POR_MIN)
				cnt_r <= cnt_r + 1'b1;
		end else if (!cnt_done)
			cnt_r <= cnt_r + 1'b1;
	end

	// ----------------------------------------------------------------
	// Reset outputs, registered from the next state
	// ----------------------------------------------------------------
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			HARD_RESET_IO_N_O <= 1'b0;
			HARD_RESET_IO_N_OE_N <= 1'b0;
			CLOCK_GEN_RESET <= 1'b1;
			CORE_RESET <= 1'b1;
		end else begin
			HARD_RESET_IO_N_O <= 1'b0;
			// Open-drain: enable low means pulling the pin low
			HARD_RESET_IO_N_OE_N <= !(state_nxt == ST_POR || state_nxt == ST_WAIT
				|| state_nxt == ST_HARD);
			CLOCK_GEN_RESET <= (state_nxt == ST_POR);
			CORE_RESET <= (state_nxt != ST_RUN);
		end
	end

	// ----------------------------------------------------------------
	// Strap capture
	// ----------------------------------------------------------------
	prs_strap_s strap_r;
	logic short_por_r;

	// Caught only on the deassertion seen in the power-on state
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET)
			strap_r <= STRAP_RST;
		else if (state_r == ST_POR && por_n_s)
			strap_r <= strap_s;
	end

	// Too-short assertion by the board is flagged, not refused
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET)
			short_por_r <= 1'b0;
		else if (state_r == ST_POR && por_n_s)
			short_por_r <= (cnt_r < POR_MIN - 1'b1); // First low cycle is not counted
	end

	assign STRAP_OUT = strap_r;

	// ----------------------------------------------------------------
	// Reset configuration word
	// ----------------------------------------------------------------
	logic [CFG_W-1:0] cfg_r;
	logic cfg_loaded_r;
	logic cfg_i2c_r;
	logic cfg_take;

	// Writes outside the power-on flow are dropped, so other resets keep it
	assign cfg_take = por_flow && (wr_cfg || I2C_CFG_VALID);

	// Host port wins when both paths write in one cycle
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET) begin
			cfg_r <= CFG_RST;
			cfg_i2c_r <= 1'b0;
		end else if (cfg_take) begin
			cfg_r <= wr_cfg ? BUS_REQ.wdata[CFG_W-1:0] : I2C_CFG_DATA;
			cfg_i2c_r <= !wr_cfg;
		end
	end

	// Loaded flag; a load beats the clear at power-on entry
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET)
			cfg_loaded_r <= 1'b0;
		else if (cfg_take)
			cfg_loaded_r <= 1'b1;
		else if (state_nxt == ST_POR && state_r != ST_POR)
			cfg_loaded_r <= 1'b0;
	end

	assign CFG_WORD = cfg_r;

	// ----------------------------------------------------------------
	// Read data, valid the cycle after the read strobe
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] status_w;

	always_comb begin
		status_w = '0;
		status_w[STAT_RUN_BIT] = (state_r == ST_RUN);
		status_w[STAT_HARD_BIT] = !HARD_RESET_IO_N_OE_N;
		status_w[STAT_SHORT_BIT] = short_por_r;
		status_w[STAT_CFGLD_BIT] = cfg_loaded_r;
		status_w[STAT_CFGI2C_BIT] = cfg_i2c_r;
		status_w[STAT_STRAP_LSB +: STRAP_W] = strap_r;
	end

	// Unmapped and write-only offsets read as zero
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET)
			BUS_RDATA <= '0;
		else if (!BUS_REQ.rd)
			BUS_RDATA <= '0;
		else if (BUS_REQ.addr == OFF_STATUS)
			BUS_RDATA <= status_w;
		else if (BUS_REQ.addr == OFF_CFG)
			BUS_RDATA <= {{(DATA_W - CFG_W){1'b0}}, cfg_r};
		else
			BUS_RDATA <= '0;
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic [CNT_W-1:0] por_age_r;
	localparam logic [CNT_W-1:0] DELAY_FULL = CNT_W'(HRST_DELAY_CYC);

	// Cycles since the synchronised deassertion, checker use only
	always_ff @(posedge CORE_CLK or posedge RESET) begin
		if (RESET)
			por_age_r <= '0;
		else if (state_r == ST_POR && por_n_s)
			por_age_r <= '0;
		else if (por_age_r != '1)
			por_age_r <= por_age_r + 1'b1;
	end

	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (RESET);

	por_entry_a: assert property (!por_n_s |=> state_r == ST_POR)
		else $error("power-on reset did not enter reset state");

	strap_sample_a: assert property (
		state_r == ST_POR && por_n_s |=> strap_r == $past(strap_s))
		else $error("straps not captured on deassertion");

	hard_delay_a: assert property (
		$rose(HARD_RESET_IO_N_OE_N) && $past(state_r) == ST_WAIT |-> por_age_r == DELAY_FULL)
		else $error("hard reset release delay wrong");

	cfg_host_a: assert property (
		por_flow && wr_cfg |=> cfg_r == $past(BUS_REQ.wdata[CFG_W-1:0]) && !cfg_i2c_r)
		else $error("host configuration write lost");

	cfg_i2c_a: assert property (
		por_flow && I2C_CFG_VALID && !wr_cfg |=> cfg_r == $past(I2C_CFG_DATA) && cfg_i2c_r)
		else $error("I2C configuration load lost");

	cfg_keep_a: assert property (!por_flow |=> $stable(cfg_r))
		else $error("configuration changed outside power-on reset");

	por_actions_a: assert property (
		state_r == ST_POR ##1 state_r == ST_POR |-> CLOCK_GEN_RESET && CORE_RESET
			&& !HARD_RESET_IO_N_OE_N)
		else $error("power-on reset actions missing");

	strap_hold_a: assert property (state_r != ST_POR |=> $stable(strap_r))
		else $error("latched straps changed");

	por_done_c: cover property (state_r == ST_WAIT ##1 state_r == ST_HREL ##[1:8] state_r == ST_RUN);
	hard_pin_c: cover property (state_r == ST_RUN && !hard_n_s ##1 state_r == ST_HARD);
	soft_c: cover property (state_r == ST_SOFT ##1 state_r == ST_RUN);
	i2c_c: cover property (por_flow && I2C_CFG_VALID && !wr_cfg);

endmodule

`default_nettype wire

/* tb/prs_reset_source.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Board reset source driving the power-on reset pin
// ----------------------------------------------------------------
module prs_reset_source (
	input wire logic clk,
	input wire logic fire,
	input wire logic [7:0] hold_cyc,
	output logic por_n
);
	// Power-up hold runs before any command arrives
	logic [7:0] hold_r = 8'h14;

	// Pin held low for hold_cyc cycles, then the pull-up wins
	always_ff @(posedge clk) begin
		if (fire) begin
			hold_r <= hold_cyc;
		end else if (hold_r != 8'h00) begin
			hold_r <= hold_r - 8'h01;
		end
	end

	assign por_n = (hold_r == 8'h00);
endmodule

`default_nettype wire

/* tb/prs_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module prs_top_tb_top;
	import prs_pkg::*;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic fire = 1'b0;
	logic [7:0] hold = 8'h10;
	logic por_n;
	prs_strap_s strap_in = 5'h00;
	logic ext_hard_n = 1'b1;
	logic hard_o;
	logic hard_oe_n;
	logic hard_pin;
	logic int_hard = 1'b0;
	logic soft_req = 1'b0;
	logic i2c_valid = 1'b0;
	logic [CFG_W-1:0] i2c_data = 16'h0000;
	prs_bus_req_s bus_req = '0;
	logic [DATA_W-1:0] rdata;
	prs_strap_s strap_out;
	logic [CFG_W-1:0] cfg_word;
	logic clk_gen_rst;
	logic core_rst;
	int bad_count = 0;
	int n_checks = 0;
	int cyc = 0;
	int t0;
	int k;
	logic [DATA_W-1:0] d;

	// ----------------------------------------------------------------
	// Clock, cycle count and the open-drain pin
	// ----------------------------------------------------------------
	always #12.5 core_clk = ~core_clk;
	// Counted on the falling edge so it is stable at every rising edge
	always @(negedge core_clk) cyc <= cyc + 1;
	// Pull-up unless either party pulls low
	assign hard_pin = (hard_oe_n ? 1'b1 : hard_o) & ext_hard_n;

	prs_reset_source prs_reset_source_inst (.clk(core_clk), .fire(fire), .hold_cyc(hold),
		.por_n(por_n));

	prs_top prs_top_inst (.CORE_CLK(core_clk), .RESET(reset), .POWER_ON_RESET_IN_N(por_n),
		.STRAP_IN(strap_in), .HARD_RESET_IO_N_I(hard_pin), .HARD_RESET_IO_N_O(hard_o),
		.HARD_RESET_IO_N_OE_N(hard_oe_n), .INT_HARD_RESET_REQ(int_hard),
		.SOFT_RESET_REQ(soft_req), .I2C_CFG_VALID(i2c_valid), .I2C_CFG_DATA(i2c_data),
		.BUS_REQ(bus_req), .BUS_RDATA(rdata), .STRAP_OUT(strap_out), .CFG_WORD(cfg_word),
		.CLOCK_GEN_RESET(clk_gen_rst), .CORE_RESET(core_rst));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic complete_run();
		if (bad_count == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wait_to(input int n);
		while (cyc < n) @(posedge core_clk);
	endtask

	task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] dt);
		@(posedge core_clk);
		bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: dt};
		@(posedge core_clk);
		bus_req <= '0;
	endtask

	task automatic bus_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] dt);
		@(posedge core_clk);
		bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
		@(posedge core_clk);
		bus_req <= '0;
		#1 dt = rdata;
	endtask

	// Straps flip after the sampling point to prove they were latched once
	task automatic por_cycle(input logic [7:0] h, input prs_strap_s st, input logic by_i2c,
		input logic [15:0] cw);
		@(posedge core_clk);
		strap_in <= st;
		hold <= h;
		fire <= 1'b1;
		@(posedge core_clk);
		fire <= 1'b0;
		forever begin
			@(posedge core_clk);
			#1;
			if (por_n) break;
		end
		t0 = cyc;
		@(posedge core_clk);
		#1 chk("por entry", 32'h6, {29'h0, clk_gen_rst, core_rst, hard_oe_n});
		wait_to(t0 + 10);
		strap_in <= ~st;
		if (by_i2c) begin
			i2c_valid <= 1'b1;
			i2c_data <= cw;
			@(posedge core_clk);
			i2c_valid <= 1'b0;
		end else begin
			bus_wr(OFF_CFG, {16'h0000, cw});
		end
		wait_to(t0 + 523);
		#1 chk("hard held", 32'h0, {31'h0, hard_oe_n});
		chk("straps", {27'h0, st}, {27'h0, strap_out});
		chk("clock gen", 32'h0, {31'h0, clk_gen_rst});
		wait_to(t0 + 524);
		#1 chk("hard freed", 32'h1, {31'h0, hard_oe_n});
		wait_to(t0 + 545);
		#1 chk("cfg word", {16'h0000, cw}, {16'h0000, cfg_word});
		chk("core run", 32'h0, {31'h0, core_rst});
	endtask

	// ----------------------------------------------------------------
	// Hang guard: the sequence needs about 2500 cycles
	// ----------------------------------------------------------------
	always @(posedge core_clk) begin
		if (cyc > 5000) begin
			bad_count++;
			complete_run();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (3) @(posedge core_clk);
		#1 chk("in reset", 32'hC, {28'h0, clk_gen_rst, core_rst, hard_oe_n, hard_o});
		@(posedge core_clk);
		reset <= 1'b0;
		por_cycle(8'h10, 5'h16, 1'b0, 16'hA5C3);
		bus_rd(OFF_STATUS, d);
		chk("status host", 32'h0000_02C9, d);
		bus_rd(OFF_CFG, d);
		chk("cfg read", 32'h0000_A5C3, d);
		bus_rd(4'hC, d);
		chk("unmapped", 32'h0, d);
		bus_rd(OFF_CTRL, d);
		chk("ctrl read", 32'h0, d);
		bus_wr(OFF_CFG, 32'h0000_1234);
		#1 chk("cfg in run", 32'h0000_A5C3, {16'h0000, cfg_word});
		// Every hard and soft reset source in turn, straps now differ
		for (k = 0; k < 5; k++) begin
			if (k > 2) begin
				bus_wr(OFF_CTRL, (k == 3) ? 32'h1 : 32'h2);
			end else begin
				@(posedge core_clk);
				int_hard <= (k == 0);
				soft_req <= (k == 1);
				ext_hard_n <= (k != 2);
			end
			repeat (5) @(posedge core_clk);
			int_hard <= 1'b0;
			soft_req <= 1'b0;
			ext_hard_n <= 1'b1;
			#1 chk("core held", 32'h1, {31'h0, core_rst});
			chk("clock kept", 32'h0, {31'h0, clk_gen_rst});
			repeat (130) @(posedge core_clk);
			#1 chk("straps kept", 32'h16, {27'h0, strap_out});
			chk("cfg kept", 32'h0000_A5C3, {16'h0000, cfg_word});
			chk("core back", 32'h0, {31'h0, core_rst});
		end
		// Short pulse from running state, loaded over I2C
		por_cycle(8'h04, 5'h0B, 1'b1, 16'h5E71);
		bus_rd(OFF_STATUS, d);
		chk("status i2c", 32'h0000_017D, d);
		// Exactly the minimum hold from running state must not be flagged short
		por_cycle(8'h10, 5'h16, 1'b0, 16'hA5C3);
		bus_rd(OFF_STATUS, d);
		chk("status exact", 32'h0000_02C9, d);
		complete_run();
	end
endmodule

`default_nettype wire
